/* File: verilog/ttcu_top.sv */
// ttcu_top: timers 0, 1 and 2 with their special function registers
// assumes: core drives sfr_addr with a one-cycle write or read strobe
//
// Contract
// RL1 - mode 0 makes timers 0 and 1 thirteen-bit up-counters
// RL2 - mode 0 uses high byte and low five bits; top three low bits untouched
// RL3 - wrap from all ones to zero sets the timer overflow flag
// RL4 - count only while run is 1 and gate is 0 or irq pin high
// RL5 - setting the run bit leaves the count bytes unchanged
// RL6 - timer function advances every core clock, no prescaler
// RL7 - mode 1 is mode 0 with all sixteen bits
// RL8 - mode 2 counts low byte, overflow reloads it from high byte
// RL9 - timer 1 in mode 3 holds its count
// RL10 - timer 0 mode 3 low byte uses timer 0 controls and flag
// RL11 - timer 0 mode 3 high byte counts clocks, uses timer 1 run and flag
// RL12 - with timer 0 split, timer 1 runs outside mode 3, stops in it
// RL13 - timer 2 mode decoded from run, baud selects and capture select
// RL14 - timer 2 autoreload: rollover sets flag and reloads from pair
// RL15 - autoreload with trigger enable: falling trigger reloads and sets trigger flag
// RL16 - capture mode counts sixteen bits, sets overflow flag, no reload
// RL17 - capture mode trigger edge copies count bytes into capture pair
// RL18 - capture trigger edge sets trigger flag for an interrupt
// RL19 - either baud select gives baud mode; overflow flag stays clear
// RL20 - baud mode trigger edges still set the trigger flag
// RL21 - baud mode ignores capture select and reloads on each overflow
// RL22 - baud selects route timer 2 or timer 1 overflow to serial port
// RL23 - timer 2 counter select picks count pin or core clock
// RL24 - mode, counter select and gate per timer in mode register
// RL25 - counter function counts synchronised falling edges of count pin
// RL26 - flags stay until written clear; count writes act at once
`timescale 1ns/1ps
module ttcu_top
  import ttcu_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // special function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // external pins
  input  wire logic       t0_count_pin,
  input  wire logic       t1_count_pin,
  input  wire logic       t2_count_pin,
  input  wire logic       external_irq_a_pin,
  input  wire logic       external_irq_b_pin,
  input  wire logic       t2_trigger_pin,
  // flags to the interrupt controller
  output logic            t0_overflow_flag,
  output logic            t1_overflow_flag,
  output logic            t2_overflow_flag,
  output logic            t2_trigger_flag,
  // baud ticks to the serial port
  output logic            rx_baud_tick,
  output logic            tx_baud_tick
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] timer01_control;
    logic [7:0] timer01_mode;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [7:0] timer2_control;
    logic [7:0] cap_lo;
    logic [7:0] cap_hi;
    logic [7:0] tl2;
    logic [7:0] th2;
    logic [7:0] rdata;
    logic       rx_tick;
    logic       tx_tick;
  } ttcu_state_t;

  ttcu_state_t st;
  ttcu_state_t next_st;

  // one timer 0/1 step, returns {overflow, high, low}
  function automatic logic [16:0] ttcu_step(input logic [1:0] mode,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [13:0] s13;
    logic [16:0] s17;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s17 = {1'b0, hi, lo} + 17'h00001;
    case (mode)
      MODE_13BIT:  ttcu_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]}; // RL1 RL2
      MODE_16BIT:  ttcu_step = s17; // RL7
      MODE_RELOAD: ttcu_step = (lo == 8'hff) ? {1'b1, hi, hi}
                                             : {1'b0, hi, lo + 8'h01}; // RL8
      default:     ttcu_step = {(lo == 8'hff), hi, lo + 8'h01};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_level;
  logic [5:0] pin_fall;

  ttcu_pin_sync #(
    .W (6)
  ) u_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .pin_in    ({t2_trigger_pin, t2_count_pin, external_irq_b_pin,
                 external_irq_a_pin, t1_count_pin, t0_count_pin}),
    .pin_level (pin_level),
    .pin_fall  (pin_fall)
  );

  // ----------------------------------------------------------------
  // count enables and decode
  // ----------------------------------------------------------------
  logic [1:0]    m0;
  logic [1:0]    m1;
  logic          t0_split;
  logic          inc0;
  logic          inc0h;
  logic          inc1;
  logic          inc2;
  logic [16:0]   step0;
  logic [16:0]   step1;
  logic          ovf0;
  logic          ovf0h;
  logic          ovf1;
  logic          ovf2;
  logic          trig2;
  logic [15:0]   t2_counter_select_inc;
  ttcu_t2_mode_t t2_mode;

  assign m0       = st.timer01_mode[T0_MODE_LSB +: 2]; // RL24
  assign m1       = st.timer01_mode[T1_MODE_LSB +: 2]; // RL24
  assign t0_split = (m0 == MODE_SPLIT);

  // timer 0, low byte keeps its own controls in split mode
  assign inc0 = st.timer01_control[T0_RUN_BIT]
              & (~st.timer01_mode[T0_GATE] | pin_level[2])            // RL4 RL10
              & (st.timer01_mode[T0_COUNTER_SEL] ? pin_fall[0] : 1'b1); // RL6 RL25
  assign step0 = ttcu_step(m0, st.tl0, st.th0);
  assign ovf0  = inc0 & step0[16]; // RL3

  // timer 0 high byte in split mode: clocks, timer 1 run bit
  assign inc0h = t0_split & st.timer01_control[T1_RUN_BIT]; // RL11
  assign ovf0h = inc0h & (st.th0 == 8'hff);

  // timer 1, freed from its run bit while timer 0 is split
  assign inc1 = (m1 != MODE_SPLIT)                              // RL9 RL12
              & (t0_split ? 1'b1
                          : st.timer01_control[T1_RUN_BIT]
                            & (~st.timer01_mode[T1_GATE] | pin_level[3])) // RL4
              & (st.timer01_mode[T1_COUNTER_SEL] ? pin_fall[1] : 1'b1); // RL6 RL25
  assign step1 = ttcu_step(m1, st.tl1, st.th1);
  assign ovf1  = inc1 & step1[16];

  // timer 2 mode decode
  always_comb begin
    if (!st.timer2_control[T2_RUN_BIT]) begin
      t2_mode = T2_OFF;
    end else if (st.timer2_control[RX_BAUD_FROM_T2] | st.timer2_control[TX_BAUD_FROM_T2]) begin
      t2_mode = T2_BAUD; // RL13 RL19
    end else if (st.timer2_control[T2_CAPTURE_SELECT]) begin
      t2_mode = T2_CAPTURE; // RL13
    end else begin
      t2_mode = T2_RELOAD; // RL13
    end
  end

  assign inc2     = (t2_mode != T2_OFF)
                  & (st.timer2_control[T2_COUNTER_SELECT] ? pin_fall[4] : 1'b1); // RL23
  assign t2_counter_select_inc = {st.th2, st.tl2} + 16'h0001;
  assign ovf2     = inc2 & ({st.th2, st.tl2} == 16'hffff);
  assign trig2    = st.timer2_control[T2_TRIGGER_ENABLE] & pin_fall[5];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;

    // timer 0 and its split high byte
    if (inc0) begin
      next_st.tl0 = step0[7:0];
      if (!t0_split) begin
        next_st.th0 = step0[15:8];
      end
    end
    if (inc0h) begin
      next_st.th0 = st.th0 + 8'h01; // RL11
    end

    // timer 1
    if (inc1) begin
      next_st.tl1 = step1[7:0];
      next_st.th1 = step1[15:8];
    end

    // timer 2 counting, reload and capture
    if (inc2) begin
      if (ovf2 && t2_mode != T2_CAPTURE) begin
        next_st.tl2 = st.cap_lo; // RL14 RL21
        next_st.th2 = st.cap_hi;
      end else begin
        next_st.tl2 = t2_counter_select_inc[7:0]; // RL16
        next_st.th2 = t2_counter_select_inc[15:8];
      end
    end
    if (trig2 && t2_mode == T2_RELOAD) begin
      next_st.tl2 = st.cap_lo; // RL15
      next_st.th2 = st.cap_hi;
    end
    if (trig2 && t2_mode == T2_CAPTURE) begin
      next_st.cap_lo = st.tl2; // RL17
      next_st.cap_hi = st.th2;
    end

    // register writes, count bytes take effect this cycle
    if (sfr_wr) begin
      case (sfr_addr)
        TIMER01_CONTROL:            next_st.timer01_control   = sfr_wdata; // RL5
        TIMER01_MODE:               next_st.timer01_mode   = sfr_wdata;
        TIMER0_COUNT_LOW:           next_st.tl0    = sfr_wdata; // RL26
        TIMER0_COUNT_HIGH:          next_st.th0    = sfr_wdata;
        TIMER1_COUNT_LOW:           next_st.tl1    = sfr_wdata;
        TIMER1_COUNT_HIGH:          next_st.th1    = sfr_wdata;
        TIMER2_CONTROL:             next_st.timer2_control  = sfr_wdata;
        TIMER2_RELOAD_CAPTURE_LOW:  next_st.cap_lo = sfr_wdata;
        TIMER2_RELOAD_CAPTURE_HIGH: next_st.cap_hi = sfr_wdata;
        TIMER2_COUNT_LOW:           next_st.tl2    = sfr_wdata;
        TIMER2_COUNT_HIGH:          next_st.th2    = sfr_wdata;
        default:                    next_st.timer01_control   = next_st.timer01_control;
      endcase
    end

    // hardware flag sets win over a clearing write
    if (ovf0) begin
      next_st.timer01_control[T0_OVERFLOW_FLAG] = 1'b1; // RL3 RL10 RL26
    end
    if (ovf0h || (ovf1 && !t0_split)) begin
      next_st.timer01_control[T1_OVERFLOW_FLAG] = 1'b1; // RL3 RL11
    end
    if (ovf2 && t2_mode != T2_BAUD) begin
      next_st.timer2_control[T2_OVERFLOW_FLAG] = 1'b1; // RL14 RL16 RL19
    end
    if (trig2) begin
      next_st.timer2_control[T2_TRIGGER_FLAG] = 1'b1; // RL15 RL18 RL20
    end

    // baud tick routing
    next_st.rx_tick = st.timer2_control[RX_BAUD_FROM_T2] ? ovf2 : ovf1; // RL22
    next_st.tx_tick = st.timer2_control[TX_BAUD_FROM_T2] ? ovf2 : ovf1; // RL22

    // read data, unmapped reads give zero
    next_st.rdata = st.rdata;
    if (sfr_rd) begin
      case (sfr_addr)
        TIMER01_CONTROL:            next_st.rdata = st.timer01_control;
        TIMER01_MODE:               next_st.rdata = st.timer01_mode;
        TIMER0_COUNT_LOW:           next_st.rdata = st.tl0;
        TIMER0_COUNT_HIGH:          next_st.rdata = st.th0;
        TIMER1_COUNT_LOW:           next_st.rdata = st.tl1;
        TIMER1_COUNT_HIGH:          next_st.rdata = st.th1;
        TIMER2_CONTROL:             next_st.rdata = st.timer2_control;
        TIMER2_RELOAD_CAPTURE_LOW:  next_st.rdata = st.cap_lo;
        TIMER2_RELOAD_CAPTURE_HIGH: next_st.rdata = st.cap_hi;
        TIMER2_COUNT_LOW:           next_st.rdata = st.tl2;
        TIMER2_COUNT_HIGH:          next_st.rdata = st.th2;
        default:                    next_st.rdata = REG_RESET;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign sfr_rdata        = st.rdata;
  assign t0_overflow_flag = st.timer01_control[T0_OVERFLOW_FLAG];
  assign t1_overflow_flag = st.timer01_control[T1_OVERFLOW_FLAG];
  assign t2_overflow_flag = st.timer2_control[T2_OVERFLOW_FLAG];
  assign t2_trigger_flag  = st.timer2_control[T2_TRIGGER_FLAG];
  assign rx_baud_tick     = st.rx_tick;
  assign tx_baud_tick     = st.tx_tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic wr_cnt0;
  logic wr_cnt1;
  logic wr_t2_counter_select;
  logic wr_cap;
  logic wr_timer01_control;
  logic wr_timer2_control;

  assign wr_cnt0  = sfr_wr & (sfr_addr == TIMER0_COUNT_LOW | sfr_addr == TIMER0_COUNT_HIGH);
  assign wr_cnt1  = sfr_wr & (sfr_addr == TIMER1_COUNT_LOW | sfr_addr == TIMER1_COUNT_HIGH);
  assign wr_t2_counter_select  = sfr_wr & (sfr_addr == TIMER2_COUNT_LOW | sfr_addr == TIMER2_COUNT_HIGH);
  assign wr_cap   = sfr_wr & (sfr_addr == TIMER2_RELOAD_CAPTURE_LOW
                            | sfr_addr == TIMER2_RELOAD_CAPTURE_HIGH);
  assign wr_timer01_control  = sfr_wr & (sfr_addr == TIMER01_CONTROL);
  assign wr_timer2_control = sfr_wr & (sfr_addr == TIMER2_CONTROL);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  low_bits_kept_a: assert property ( // RL2
    (m0 == MODE_13BIT && !wr_cnt0) |=> st.tl0[7:5] == $past(st.tl0[7:5]))
    else $error("mode 0 changed the upper low-byte bits");

  t0_wrap_a: assert property ( // RL3
    (m0 == MODE_16BIT && inc0 && {st.th0, st.tl0} == 16'hffff && !wr_cnt0)
      |=> (st.timer01_control[T0_OVERFLOW_FLAG] && {st.th0, st.tl0} == 16'h0000))
    else $error("sixteen-bit wrap did not set flag and clear count");

  run_off_hold_a: assert property ( // RL4
    (!st.timer01_control[T0_RUN_BIT] && !t0_split && !wr_cnt0)
      |=> ($stable(st.tl0) && $stable(st.th0)))
    else $error("timer 0 moved while stopped");

  every_clock_a: assert property ( // RL6
    (m0 == MODE_16BIT && st.timer01_control[T0_RUN_BIT] && !st.timer01_mode[T0_GATE]
      && !st.timer01_mode[T0_COUNTER_SEL] && !wr_cnt0 && st.tl0 != 8'hff)
      |=> st.tl0 == $past(st.tl0) + 8'h01)
    else $error("timer function missed a core clock");

  low_reload_a: assert property ( // RL8
    (m0 == MODE_RELOAD && inc0 && st.tl0 == 8'hff && !wr_cnt0)
      |=> (st.tl0 == $past(st.th0) && $stable(st.th0)))
    else $error("mode 2 reload wrong");

  t1_frozen_a: assert property ( // RL9
    (m1 == MODE_SPLIT && !wr_cnt1) |=> ($stable(st.tl1) && $stable(st.th1)))
    else $error("timer 1 counted in mode 3");

  split_high_a: assert property ( // RL11
    (t0_split && st.timer01_control[T1_RUN_BIT] && st.th0 == 8'hff && !wr_cnt0)
      |=> (st.timer01_control[T1_OVERFLOW_FLAG] && st.th0 == 8'h00))
    else $error("split high byte did not set timer 1 flag");

  t2_reload_a: assert property ( // RL14
    (t2_mode == T2_RELOAD && ovf2 && !wr_t2_counter_select && !wr_timer2_control)
      |=> ({st.th2, st.tl2} == $past({st.cap_hi, st.cap_lo})
           && st.timer2_control[T2_OVERFLOW_FLAG]))
    else $error("timer 2 rollover did not reload");

  t2_capture_a: assert property ( // RL17
    (t2_mode == T2_CAPTURE && trig2 && !wr_cap && !wr_timer2_control)
      |=> ({st.cap_hi, st.cap_lo} == $past({st.th2, st.tl2})
           && st.timer2_control[T2_TRIGGER_FLAG]))
    else $error("capture edge did not copy count");

  baud_no_flag_a: assert property ( // RL19
    (t2_mode == T2_BAUD && !st.timer2_control[T2_OVERFLOW_FLAG] && !wr_timer2_control)
      |=> !st.timer2_control[T2_OVERFLOW_FLAG])
    else $error("overflow flag set in baud mode");

  set_wins_a: assert property ( // RL26
    (ovf0 && wr_timer01_control && !sfr_wdata[T0_OVERFLOW_FLAG]) |=> st.timer01_control[T0_OVERFLOW_FLAG])
    else $error("clearing write beat a same-cycle overflow");

endmodule

/* File: verilog/ttcu_pkg.sv */
// ttcu_pkg: shared constants and types of the three timer/counter unit
// assumes: an 8-bit special function register bus from the core
package ttcu_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER01_CONTROL            = 8'h88;
  localparam logic [7:0] TIMER01_MODE               = 8'h89;
  localparam logic [7:0] TIMER0_COUNT_LOW           = 8'h8a;
  localparam logic [7:0] TIMER1_COUNT_LOW           = 8'h8b;
  localparam logic [7:0] TIMER0_COUNT_HIGH          = 8'h8c;
  localparam logic [7:0] TIMER1_COUNT_HIGH          = 8'h8d;
  localparam logic [7:0] TIMER2_CONTROL             = 8'hc8;
  localparam logic [7:0] TIMER2_RELOAD_CAPTURE_LOW  = 8'hca;
  localparam logic [7:0] TIMER2_RELOAD_CAPTURE_HIGH = 8'hcb;
  localparam logic [7:0] TIMER2_COUNT_LOW           = 8'hcc;
  localparam logic [7:0] TIMER2_COUNT_HIGH          = 8'hcd;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // timer01_control
  localparam int T1_OVERFLOW_FLAG = 7;
  localparam int T1_RUN_BIT       = 6;
  localparam int T0_OVERFLOW_FLAG = 5;
  localparam int T0_RUN_BIT       = 4;
  // timer01_mode, timer 1 in the upper nibble, timer 0 in the lower
  localparam int T1_GATE          = 7;
  localparam int T1_COUNTER_SEL   = 6;
  localparam int T1_MODE_LSB      = 4;
  localparam int T0_GATE          = 3;
  localparam int T0_COUNTER_SEL   = 2;
  localparam int T0_MODE_LSB      = 0;
  // timer2_control
  localparam int T2_OVERFLOW_FLAG  = 7;
  localparam int T2_TRIGGER_FLAG   = 6;
  localparam int RX_BAUD_FROM_T2   = 5;
  localparam int TX_BAUD_FROM_T2   = 4;
  localparam int T2_TRIGGER_ENABLE = 3;
  localparam int T2_RUN_BIT        = 2;
  localparam int T2_COUNTER_SELECT = 1;
  localparam int T2_CAPTURE_SELECT = 0;

  // ----------------------------------------------------------------
  // reset values and mode codes
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // timer 2 operating mode
  typedef enum logic [1:0] {
    T2_OFF     = 2'b00,
    T2_RELOAD  = 2'b01,
    T2_CAPTURE = 2'b10,
    T2_BAUD    = 2'b11
  } ttcu_t2_mode_t;

endpackage

/* File: verilog/ttcu_pin_sync.sv */
// ttcu_pin_sync: two-flop synchroniser with falling edge detect per pin
// assumes: pins are asynchronous to core_clk
`timescale 1ns/1ps
module ttcu_pin_sync
  import ttcu_pkg::*;
#(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // raw pins
  input  wire logic [W-1:0] pin_in,
  // synchronised level and one-cycle falling edge
  output logic      [W-1:0] pin_level,
  output logic      [W-1:0] pin_fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prior;
  } ttcu_sync_t;

  ttcu_sync_t st;
  ttcu_sync_t next_st;

  // shift chain, first stage read only by the second
  always_comb begin
    next_st.meta   = pin_in;
    next_st.stable = st.meta;
    next_st.prior  = st.stable;
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // edge and level from settled stages
  assign pin_level = st.stable;
  assign pin_fall  = st.prior & ~st.stable;

endmodule

/* File: verif/ttcu_core_model.sv */
// ttcu_core_model: core side of the special function register bus
// assumes: tasks are entered shortly after a rising edge of core_clk
`timescale 1ns/1ps
module ttcu_core_model
  import ttcu_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // bus toward the timers
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata,
  // read data back
  input  wire logic [7:0] sfr_rdata
);
  // idle bus at time zero
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
  end

  // released lines show the inverse so stale values never pass
  task automatic release_bus();
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_addr  = ~sfr_addr;
    sfr_wdata = ~sfr_wdata;
  endtask

  // one-cycle write, taken at the next rising edge; strobe held for a follower
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_rd    = 1'b0;
    sfr_wr    = 1'b1;
    @(posedge core_clk);
    #2;
  endtask

  // one-cycle read, data settled just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_wr   = 1'b0;
    sfr_rd   = 1'b1;
    @(posedge core_clk);
    #2;
    d = sfr_rdata;
  endtask

  // release the bus, then let n edges pass with it idle
  task automatic idle(input int n);
    release_bus();
    repeat (n) @(posedge core_clk);
    #2;
  endtask
endmodule

/* File: verif/ttcu_top_tb.sv */
// ttcu_top_tb: self-checking bench of the three timer/counter unit
// assumes: core model drives the bus, bench drives pins 2 ns after edges
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, e, g)
module ttcu_top_tb;
  import ttcu_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       core_clk;
  logic       reset;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       t0_pin;
  logic       t1_pin;
  logic       t2_pin;
  logic       irq_b;
  logic       irq_a;
  logic       trig;
  logic [5:0] fl;
  logic [5:0] seen;
  int         errors;
  int         cmp_count;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  ttcu_core_model core_u (.core_clk(core_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  ttcu_top dut_u (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .t0_count_pin(t0_pin), .t1_count_pin(t1_pin), .t2_count_pin(t2_pin),
    .external_irq_a_pin(irq_a), .external_irq_b_pin(irq_b), .t2_trigger_pin(trig),
    .t0_overflow_flag(fl[0]), .t1_overflow_flag(fl[1]), .t2_overflow_flag(fl[2]),
    .t2_trigger_flag(fl[3]), .rx_baud_tick(fl[4]), .tx_baud_tick(fl[5]));

  // clock, 25 ns period
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // sticky record of flags and ticks
  always @(posedge core_clk) seen <= seen | fl;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    core_u.rd(a, d);
    `CHK(n, e, d);
  endtask

  // run bit on for exactly n counting edges, then off
  task automatic run(input logic [7:0] a, input logic [7:0] on, input int n);
    seen = 6'h00;
    core_u.wr(a, on);
    core_u.idle(n - 1);
    core_u.wr(a, 8'h00);
  endtask

  task automatic pre(input logic [7:0] mode, input logic [7:0] lo, input logic [7:0] hi);
    core_u.wr(TIMER01_MODE, mode);
    core_u.wr(TIMER0_COUNT_LOW, lo);
    core_u.wr(TIMER0_COUNT_HIGH, hi);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] a [12] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hca,
                           8'hcb, 8'hcc, 8'hcd, 8'h90};
    foreach (a[i]) rchk("reset value", a[i], REG_RESET);
    $display("t_reset done");
  endtask

  task automatic t_mode0();
    pre(8'h00, 8'hff, 8'hff);
    run(TIMER01_CONTROL, 8'h10, 2);
    rchk("m0 low", TIMER0_COUNT_LOW, 8'he1);
    rchk("m0 high", TIMER0_COUNT_HIGH, 8'h00);
    `CHK("m0 flag", 8'(seen[0]), 8'h01);
    $display("t_mode0 done");
  endtask

  task automatic t_mode1();
    pre(8'h01, 8'h10, 8'h00);
    run(TIMER01_CONTROL, 8'h10, 40);
    rchk("m1 low", TIMER0_COUNT_LOW, 8'h38);
    pre(8'h01, 8'hff, 8'hff);
    run(TIMER01_CONTROL, 8'h10, 1);
    rchk("m1 wrap", TIMER0_COUNT_HIGH, 8'h00);
    `CHK("m1 flag", 8'(seen[0]), 8'h01);
    $display("t_mode1 done");
  endtask

  task automatic t_mode2();
    pre(8'h02, 8'hfe, 8'h80);
    run(TIMER01_CONTROL, 8'h10, 3);
    rchk("m2 low", TIMER0_COUNT_LOW, 8'h81);
    rchk("m2 high", TIMER0_COUNT_HIGH, 8'h80);
    `CHK("m2 flag", 8'(seen[0]), 8'h01);
    $display("t_mode2 done");
  endtask

  task automatic t_gate();
    pre(8'h09, 8'h05, 8'h00);
    run(TIMER01_CONTROL, 8'h10, 5);
    rchk("gate low", TIMER0_COUNT_LOW, 8'h05);
    irq_a = 1'b1;
    core_u.idle(3);
    run(TIMER01_CONTROL, 8'h10, 5);
    rchk("gate high", TIMER0_COUNT_LOW, 8'h0a);
    irq_a = 1'b0;
    $display("t_gate done");
  endtask

  task automatic t_counter();
    irq_b = 1'b0;
    pre(8'hd5, 8'h00, 8'h00);
    core_u.wr(TIMER01_CONTROL, 8'h50);
    core_u.wr(TIMER2_CONTROL, 8'h06);
    repeat (3) begin
      t0_pin = 1'b0;
      t1_pin = 1'b0;
      t2_pin = 1'b0;
      core_u.idle(3);
      t0_pin = 1'b1;
      t1_pin = 1'b1;
      t2_pin = 1'b1;
      core_u.idle(3);
    end
    core_u.idle(3);
    core_u.wr(TIMER01_CONTROL, 8'h00);
    core_u.wr(TIMER2_CONTROL, 8'h00);
    irq_b = 1'b1;
    rchk("pin count", TIMER0_COUNT_LOW, 8'h03);
    rchk("t1 gated", TIMER1_COUNT_LOW, 8'h00);
    rchk("t2 pin count", TIMER2_COUNT_LOW, 8'h03);
    $display("t_counter done");
  endtask

  task automatic t_split();
    pre(8'h03, 8'h07, 8'hfe);
    run(TIMER01_CONTROL, 8'h40, 2);
    rchk("split high", TIMER0_COUNT_HIGH, 8'h00);
    rchk("split low", TIMER0_COUNT_LOW, 8'h07);
    `CHK("split flags", 8'(seen[1:0]), 8'h02);
    core_u.wr(TIMER01_MODE, 8'h30);
    core_u.wr(TIMER1_COUNT_LOW, 8'h44);
    run(TIMER01_CONTROL, 8'h40, 5);
    rchk("t1 hold", TIMER1_COUNT_LOW, 8'h44);
    $display("t_split done");
  endtask

  task automatic t2_setup(input logic [7:0] lo, input logic [7:0] hi);
    core_u.wr(TIMER2_RELOAD_CAPTURE_LOW, 8'h34);
    core_u.wr(TIMER2_RELOAD_CAPTURE_HIGH, 8'h12);
    core_u.wr(TIMER2_COUNT_LOW, lo);
    core_u.wr(TIMER2_COUNT_HIGH, hi);
  endtask

  task automatic t_t2_reload();
    t2_setup(8'hff, 8'hff);
    run(TIMER2_CONTROL, 8'h04, 2);
    rchk("t2 reload", TIMER2_COUNT_LOW, 8'h35);
    `CHK("t2 ovf flag", 8'(seen[2]), 8'h01);
    t2_setup(8'h00, 8'h00);
    seen = 6'h00;
    core_u.wr(TIMER2_CONTROL, 8'h0c);
    trig = 1'b0;
    core_u.idle(8);
    core_u.wr(TIMER2_CONTROL, 8'h00);
    trig = 1'b1;
    rchk("trig reload", TIMER2_COUNT_HIGH, 8'h12);
    `CHK("trig flag", 8'(seen[3]), 8'h01);
    $display("t_t2_reload done");
  endtask

  task automatic t_t2_capture();
    t2_setup(8'h00, 8'h56);
    seen = 6'h00;
    core_u.wr(TIMER2_CONTROL, 8'h0d);
    trig = 1'b0;
    core_u.idle(8);
    core_u.wr(TIMER2_CONTROL, 8'h00);
    trig = 1'b1;
    rchk("cap high", TIMER2_RELOAD_CAPTURE_HIGH, 8'h56);
    `CHK("cap flag", 8'(seen[3]), 8'h01);
    t2_setup(8'hff, 8'hff);
    run(TIMER2_CONTROL, 8'h05, 2);
    rchk("cap no reload", TIMER2_COUNT_LOW, 8'h01);
    `CHK("cap ovf", 8'(seen[2]), 8'h01);
    $display("t_t2_capture done");
  endtask

  task automatic t_t2_baud();
    t2_setup(8'hff, 8'hff);
    run(TIMER2_CONTROL, 8'h35, 3);
    rchk("baud reload", TIMER2_COUNT_LOW, 8'h36);
    `CHK("baud ticks", 8'(seen[5:2]), 8'h0c);
    t2_setup(8'h00, 8'h00);
    seen = 6'h00;
    core_u.wr(TIMER2_CONTROL, 8'h2c);
    trig = 1'b0;
    core_u.idle(6);
    `CHK("baud trig", 8'(seen[3:2]), 8'h02);
    core_u.wr(TIMER2_CONTROL, 8'h00);
    trig = 1'b1;
    $display("t_t2_baud done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    cmp_count = 0;
    seen = 6'h00;
    reset = 1'b1;
    t0_pin = 1'b1;
    t1_pin = 1'b1;
    t2_pin = 1'b1;
    irq_b = 1'b1;
    irq_a = 1'b0;
    trig = 1'b1;
    repeat (10) @(posedge core_clk);
    #2;
    reset = 1'b0;
    core_u.idle(1);
    t_reset();
    t_mode0();
    t_mode1();
    t_mode2();
    t_gate();
    t_counter();
    t_split();
    t_t2_reload();
    t_t2_capture();
    t_t2_baud();
    wrap_up();
  end

  initial begin
    #(20000 * 25);
    errors++;
    wrap_up();
  end
endmodule
